// ==== include/vout_regs_pkg.sv ====
package vout_regs_pkg;

  // Command codes of the two registers on the serial port.
  localparam logic [7:0] CMD_OUTPUT_OFFSET_TRIM = 8'ha8;
  localparam logic [7:0] CMD_LOOP_COMP_MAIN     = 8'ha9;

  // Field positions inside loop_comp_main.
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 4;
  localparam int LL_MSB   = 3;
  localparam int LL_LSB   = 0;

  // Reset value of every register before the nonvolatile copy lands.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Selector codes.
  localparam logic [1:0] VID_STEP5_A   = 2'h1;
  localparam logic [1:0] VID_STEP5_B   = 2'h2;
  localparam logic [1:0] SRC_SERIAL    = 2'h2;
  localparam logic [3:0] GAIN_LAST_OK  = 4'hb;

  // Step weights, in units of 0.5 mV.
  localparam logic [4:0] STEP5_HALFMV  = 5'h0a;
  localparam logic [4:0] STEP10_HALFMV = 5'h14;

  // Offset moves at half of the fast slew rate.
  localparam int SLEW_OFFSET_DIV = 2;

  // Seven-bit bus address of the device; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ADDR  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_WDATA = 4'b0011,
    ST_ACK   = 4'b0100,
    ST_RDATA = 4'b0101,
    ST_RACK  = 4'b0110,
    ST_WAIT  = 4'b0111
  } link_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } reg_write_s;

endpackage

// ==== design/serial_byte_port.sv ====
`timescale 1ns/1ps
module serial_byte_port
  import vout_regs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      cur_cmd,
  input  wire logic       cmd_ok,
  input  wire logic [7:0] rd_data,
  output reg_write_s      wr_req
);

  link_state_e state_reg;
  link_state_e after_ack_reg;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  cnt_reg;
  logic [7:0]  shift_reg;
  logic        master_ack_reg;

  wire start_seen = scl_in && scl_q && sda_q && !sda_in;
  wire stop_seen  = scl_in && scl_q && !sda_q && sda_in;
  wire scl_rise   = scl_in && !scl_q;
  wire scl_fall   = !scl_in && scl_q;
  wire receiving  = (state_reg == ST_ADDR) || (state_reg == ST_CMD)
                    || (state_reg == ST_WDATA);
  wire byte_full  = (cnt_reg == BITS_PER_BYTE);
  wire addr_hit   = (shift_reg[7:1] == DEV_ADDR);

  // Open drain: the pin is only ever pulled low.
  assign sda_out = 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= ST_IDLE;
      after_ack_reg  <= ST_IDLE;
      cnt_reg        <= 4'h0;
      shift_reg      <= REG_RESET;
      sda_oe         <= 1'b0;
      cur_cmd        <= REG_RESET;
      master_ack_reg <= 1'b0;
      wr_req         <= '0;
    end
    else
    begin
      wr_req.valid <= 1'b0;
      if (start_seen)
      begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
        sda_oe    <= 1'b0;
      end
      else if (stop_seen)
      begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end
      else if (receiving && scl_rise)
      begin
        shift_reg <= {shift_reg[6:0], sda_in};
        cnt_reg   <= cnt_reg + 4'h1;
        // The command is latched on its last rising edge, so that its
        // acknowledge is judged on the code just received.
        if (state_reg == ST_CMD && cnt_reg == BITS_PER_BYTE - 4'h1)
          cur_cmd <= {shift_reg[6:0], sda_in};
      end
      else if (receiving && scl_fall && byte_full)
      begin
        state_reg <= ST_ACK;
        sda_oe    <= 1'b0;
        unique case (state_reg)
          ST_ADDR:
          begin
            sda_oe        <= addr_hit;
            after_ack_reg <= !addr_hit ? ST_IDLE
                           : (shift_reg[0] ? ST_RDATA : ST_CMD);
          end
          ST_CMD:
          begin
            sda_oe        <= cmd_ok;
            after_ack_reg <= cmd_ok ? ST_WDATA : ST_IDLE;
          end
          default:
          begin
            // Write Byte carries one data byte; more are refused.
            sda_oe        <= 1'b1;
            wr_req.valid  <= 1'b1;
            wr_req.cmd    <= cur_cmd;
            wr_req.data   <= shift_reg;
            after_ack_reg <= ST_WAIT;
          end
        endcase
      end
      else if (state_reg == ST_ACK && scl_fall)
      begin
        cnt_reg   <= 4'h0;
        state_reg <= after_ack_reg;
        sda_oe    <= 1'b0;
        if (after_ack_reg == ST_RDATA)
        begin
          shift_reg <= {rd_data[6:0], 1'b0};
          sda_oe    <= !rd_data[7];
          cnt_reg   <= 4'h1;
        end
      end
      else if (state_reg == ST_RDATA && scl_fall)
      begin
        if (byte_full)
        begin
          sda_oe    <= 1'b0;
          state_reg <= ST_RACK;
        end
        else
        begin
          sda_oe    <= !shift_reg[7];
          shift_reg <= {shift_reg[6:0], 1'b0};
          cnt_reg   <= cnt_reg + 4'h1;
        end
      end
      else if (state_reg == ST_RDATA && scl_rise && byte_full)
      begin
        sda_oe <= sda_oe;
      end
      else if (state_reg == ST_RACK && scl_rise)
      begin
        master_ack_reg <= !sda_in;
      end
      else if (state_reg == ST_RACK && scl_fall)
      begin
        // A repeated read reloads the same byte one SCL clock late, so its first bit is released and bit 0 falls on the ack clock.
        state_reg <= master_ack_reg ? ST_ACK : ST_WAIT;
        after_ack_reg <= ST_RDATA;
      end
    end
  end

endmodule // serial_byte_port

// ==== design/vout_offset_comp_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - The offset trim is added to the commanded output voltage target.
// - Offset-caused voltage changes move at half the fast slew rate.
// - The offset applies only under the serial output-source selection.
// - Step select 01b or 10b weighs each trim LSB at 0.5 mV.
// - In 5 mV step mode the trim is signed, -64 to +63.5 mV.
// - Step select 00b or 11b weighs each trim LSB at 1.0 mV.
// - In 10 mV step mode the trim is signed, -128 to +127 mV.
// - Compensation register takes single-byte writes; a read goes on while the host acknowledges.
// - Compensation byte is unsigned and takes effect at once on write.
// - Bits 7:4 choose Ac_path_gain 0.3 through 7.0 per code.
// - Bits 3:0 choose AC load line 0.5 through 15.0 per code.
// - Source select 10b drives the output to the serially written target.
module vout_offset_comp_regs
  import vout_regs_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic [7:0]         nvm_offset_trim,
  input  wire logic [7:0]         nvm_loop_comp,
  input  wire logic [1:0]         vid_step_select,
  input  wire logic [1:0]         vout_source_select,
  input  wire logic [15:0]        slew_rate_config,
  input  wire logic [7:0]         vout_target_cmd,
  input  wire logic [7:0]         ext_vid_code,
  output logic signed [13:0]      vout_ref_halfmv,
  output logic signed [9:0]       offset_applied_halfmv,
  output logic [3:0]              ac_path_gain,
  output logic [3:0]              ac_load_line,
  output logic [7:0]              ac_path_gain_tenths,
  output logic [7:0]              ac_load_line_tenths,
  output logic                    ac_path_gain_reserved
);

  function automatic logic step5(input logic [1:0] sel);
    step5 = (sel == VID_STEP5_A) || (sel == VID_STEP5_B);
  endfunction

  function automatic logic [7:0] gain_tenths(input logic [3:0] code);
    unique case (code)
      4'h0: gain_tenths = 8'h03;
      4'h1: gain_tenths = 8'h05;
      4'h8: gain_tenths = 8'h28;
      4'h9: gain_tenths = 8'h32;
      4'ha: gain_tenths = 8'h3c;
      4'hb: gain_tenths = 8'h46;
      4'hc, 4'hd, 4'he, 4'hf: gain_tenths = 8'h00;
      default: gain_tenths = 8'({4'h0, code} * 8'h05);
    endcase
  endfunction

  function automatic logic [7:0] load_line_tenths(input logic [3:0] code);
    unique case (code)
      4'h8: load_line_tenths = 8'h32;
      4'h9: load_line_tenths = 8'h3c;
      4'ha: load_line_tenths = 8'h46;
      4'hb: load_line_tenths = 8'h5a;
      4'hc: load_line_tenths = 8'h64;
      4'hd: load_line_tenths = 8'h78;
      4'he: load_line_tenths = 8'h82;
      4'hf: load_line_tenths = 8'h96;
      default: load_line_tenths = 8'(({4'h0, code} + 8'h01) * 8'h05);
    endcase
  endfunction

  logic [7:0]         output_offset_trim_reg;
  logic [7:0]         loop_comp_main_reg;
  logic               nvm_load_reg;
  logic [16:0]        slew_cnt_reg;
  logic signed [9:0]  offset_target;
  logic [7:0]         rd_data;
  logic [7:0]         cur_cmd;
  logic [7:0]         vid_sel;
  reg_write_s         wr_req;

  wire cmd_is_trim = (cur_cmd == CMD_OUTPUT_OFFSET_TRIM);
  wire cmd_is_comp = (cur_cmd == CMD_LOOP_COMP_MAIN);
  wire cmd_ok      = cmd_is_trim || cmd_is_comp;
  wire wr_trim     = wr_req.valid && (wr_req.cmd == CMD_OUTPUT_OFFSET_TRIM);
  wire wr_comp     = wr_req.valid && (wr_req.cmd == CMD_LOOP_COMP_MAIN);
  wire src_serial  = (vout_source_select == SRC_SERIAL);
  wire fine_step   = step5(vid_step_select);

  serial_byte_port u_port (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .cur_cmd (cur_cmd),
    .cmd_ok  (cmd_ok),
    .rd_data (rd_data),
    .wr_req  (wr_req)
  );

  // Reads echo whatever was last written or loaded.
  assign rd_data = cmd_is_trim ? output_offset_trim_reg
                 : (cmd_is_comp ? loop_comp_main_reg : REG_RESET);

  // The nonvolatile copy is caught one edge after reset release, since an
  // asynchronous reset may only load constants.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      nvm_load_reg           <= 1'b1;
      output_offset_trim_reg <= REG_RESET;
      loop_comp_main_reg     <= REG_RESET;
    end
    else
    begin
      nvm_load_reg <= 1'b0;
      if (nvm_load_reg)
      begin
        output_offset_trim_reg <= nvm_offset_trim;
        loop_comp_main_reg     <= nvm_loop_comp;
      end
      else
      begin
        if (wr_trim)
          output_offset_trim_reg <= wr_req.data;
        if (wr_comp)
          loop_comp_main_reg <= wr_req.data;
      end
    end
  end

  // Compensation fields drive the loop directly, with no restart needed.
  assign ac_path_gain        = loop_comp_main_reg[GAIN_MSB:GAIN_LSB];
  assign ac_load_line        = loop_comp_main_reg[LL_MSB:LL_LSB];
  assign ac_path_gain_tenths      = gain_tenths(ac_path_gain);
  assign ac_load_line_tenths = load_line_tenths(ac_load_line);
  // Reserved gain codes are flagged rather than trusted.
  assign ac_path_gain_reserved    = (ac_path_gain > GAIN_LAST_OK);

  // Trim in 0.5 mV units: as is in fine steps, doubled in coarse steps.
  assign offset_target = !src_serial ? 10'sh000
                       : fine_step ? 10'(signed'(output_offset_trim_reg))
                       : 10'(signed'({output_offset_trim_reg, 1'b0}));

  // slew_rate_config holds cycles per 0.5 mV at the fast rate.
  wire [16:0] slew_period = 17'(slew_rate_config) * 17'(SLEW_OFFSET_DIV);
  wire        slew_tick   = (slew_cnt_reg + 17'h1 >= slew_period);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      slew_cnt_reg          <= 17'h0;
      offset_applied_halfmv <= 10'sh000;
    end
    else
    begin
      slew_cnt_reg <= slew_tick ? 17'h0 : slew_cnt_reg + 17'h1;
      if (slew_tick && offset_applied_halfmv < offset_target)
        offset_applied_halfmv <= offset_applied_halfmv + 10'sh001;
      else if (slew_tick && offset_applied_halfmv > offset_target)
        offset_applied_halfmv <= offset_applied_halfmv - 10'sh001;
    end
  end

  assign vid_sel = src_serial ? vout_target_cmd : ext_vid_code;

  // Base target plus the slewed offset.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      vout_ref_halfmv <= 14'sh0000;
    else
      vout_ref_halfmv <= signed'(14'({6'h00, vid_sel}
                         * {9'h000, fine_step ? STEP5_HALFMV : STEP10_HALFMV}))
                         + 14'(offset_applied_halfmv);
  end

endmodule // vout_offset_comp_regs

// ==== verif/i2c_host_model.sv ====
`timescale 1ns/1ps
module i2c_host_model
  import vout_regs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // SCL stands high between frames; a released bit reads the pull-up.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic e(input logic a, input logic b);
    sda_low = a;
    tick();
    scl = b;
    tick();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
    output logic n);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, n);
  endtask
  task automatic stop;
    e(1'b1, 1'b1);
    sda_low = 1'b0;
    tick();
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic [2:0] n;
    e(1'b1, 1'b0);
    xfer({DEV_ADDR, 1'b0}, q, n[0]);
    xfer(c, q, n[1]);
    xfer(d, q, n[2]);
    stop();
    ok = (n === 3'b000);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic [3:0] n;
    e(1'b1, 1'b0);
    xfer({DEV_ADDR, 1'b0}, q, n[0]);
    xfer(c, q, n[1]);
    e(1'b0, 1'b1);
    e(1'b1, 1'b0);
    xfer({DEV_ADDR, 1'b1}, q, n[2]);
    xfer(8'hff, d, n[3]);
    stop();
    ok = (n === 4'b1000);
  endtask
endmodule // i2c_host_model

// ==== verif/vout_regs_asserts.sv ====
`timescale 1ns/1ps
module vout_regs_asserts
  import vout_regs_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               scl_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  input wire logic [1:0]         vout_source_select,
  input wire logic signed [9:0]  offset_applied_halfmv,
  input wire logic [3:0]         ac_path_gain,
  input wire logic [3:0]         ac_load_line,
  input wire logic [7:0]         ac_path_gain_tenths,
  input wire logic [7:0]         ac_load_line_tenths,
  input wire logic               ac_path_gain_reserved
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_gain_flag:
  assert property (ac_path_gain_reserved == (ac_path_gain > GAIN_LAST_OK))
    else $error("gain reserved flag wrong");
  a_gain_rsv:
  assert property (ac_path_gain_reserved |-> ac_path_gain_tenths == 8'h00)
    else $error("reserved gain not zero");
  a_gain_mid:
  assert property (ac_path_gain inside {[4'h2:4'h8]} |-> ac_path_gain_tenths
    == {2'b00, ac_path_gain, 2'b00} + {4'h0, ac_path_gain})
    else $error("gain tenths wrong");
  a_ll_low:
  assert property (ac_load_line <= 4'h7 |-> ac_load_line_tenths
    == ({4'h0, ac_load_line} + 8'h01) * 8'h05)
    else $error("load line tenths wrong");
  a_ll_top:
  assert property (ac_load_line == 4'hf |-> ac_load_line_tenths == 8'h96)
    else $error("top load line wrong");
  a_slew_hold:
  assert property ($changed(offset_applied_halfmv)
    |=> $stable(offset_applied_halfmv))
    else $error("offset slews too fast");
  a_slew_step:
  assert property ($changed(offset_applied_halfmv) |->
    (offset_applied_halfmv - $past(offset_applied_halfmv) == 10'sh001) ||
    ($past(offset_applied_halfmv) - offset_applied_halfmv == 10'sh001))
    else $error("offset step too large");
  a_src_gate:
  assert property ((vout_source_select != SRC_SERIAL)[*2] ##0
    (offset_applied_halfmv == 10'sh000) |=> offset_applied_halfmv == 10'sh000)
    else $error("offset moved off serial source");
  a_oe_scl_low:
  assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda driven change while scl high");
  a_sda_open:
  assert property (sda_out == 1'b0)
    else $error("sda driven high");
endmodule // vout_regs_asserts

// ==== verif/vout_offset_comp_regs_test.sv ====
`timescale 1ns/1ps
module vout_offset_comp_regs_test;
  import vout_regs_pkg::*;
  localparam logic [7:0] GT [16] = '{8'h03, 8'h05, 8'h0a, 8'h0f, 8'h14,
    8'h19, 8'h1e, 8'h23, 8'h28, 8'h32, 8'h3c, 8'h46, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam logic [7:0] LT [16] = '{8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19,
    8'h1e, 8'h23, 8'h28, 8'h32, 8'h3c, 8'h46, 8'h5a, 8'h64, 8'h78, 8'h82,
    8'h96};
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [1:0]         step = 2'h1;
  logic [1:0]         src = 2'h2;
  logic               scl;
  logic               host_low;
  logic               sda_oe;
  wire                sda = !(host_low || sda_oe);
  logic signed [13:0] vref;
  logic signed [9:0]  voff;
  logic [3:0]         gain;
  logic [3:0]         ll;
  logic [7:0]         gain_t;
  logic [7:0]         ll_t;
  logic               res;
  logic [7:0]         rdv;
  logic [7:0]         nvm_comp = 8'h37;
  logic               ok;
  int                 error_cnt = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  always #10 clk_sys = ~clk_sys;
  i2c_host_model i_host (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_low(host_low));
  vout_offset_comp_regs i_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .nvm_offset_trim(8'h90),
    .nvm_loop_comp(nvm_comp), .vid_step_select(step), .vout_source_select(src),
    .slew_rate_config(16'h0001), .vout_target_cmd(8'h40),
    .ext_vid_code(8'h21), .vout_ref_halfmv(vref),
    .offset_applied_halfmv(voff), .ac_path_gain(gain), .ac_load_line(ll),
    .ac_path_gain_tenths(gain_t), .ac_load_line_tenths(ll_t),
    .ac_path_gain_reserved(res));
  task automatic chk(input string n, input logic [15:0] got,
    input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset;
    chk("gain", 16'(gain), 16'h0003);
    chk("ll", 16'(ll), 16'h0007);
    i_host.rd(CMD_OUTPUT_OFFSET_TRIM, rdv, ok);
    chk("trim", 16'(rdv), 16'h0090);
  endtask
  task automatic t_comp;
    logic [7:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = {4'(i % 12), 4'(15 - i)};
      i_host.wr(CMD_LOOP_COMP_MAIN, v, ok);
      chk("wr ack", 16'(ok), 16'h0001);
      chk("gain", 16'(gain), 16'(v[7:4]));
      chk("ll", 16'(ll), 16'(v[3:0]));
      chk("gain_t", 16'(gain_t), 16'(GT[i % 12]));
      chk("ll_t", 16'(ll_t), 16'(LT[15 - i]));
      chk("rsv", 16'(res), 16'h0000);
      i_host.rd(CMD_LOOP_COMP_MAIN, rdv, ok);
      chk("rd ack", 16'(ok), 16'h0001);
      chk("rd", 16'(rdv), 16'(v));
    end
    i_host.wr(8'ha7, 8'h55, ok);
    chk("bad cmd", 16'(ok), 16'h0000);
  endtask
  // Reserved gain codes reach the test only from the stored copy; t_comp never writes one from the host.
  task automatic t_nvm;
    nvm_comp = 8'hc6;
    rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("gain rst", 16'(gain), 16'h0000);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("gain nvm", 16'(gain), 16'h000c);
    chk("rsv nvm", 16'(res), 16'h0001);
    chk("gain_t rsv", 16'(gain_t), 16'h0000);
    @(negedge clk_sys);
    i_host.rd(CMD_LOOP_COMP_MAIN, rdv, ok);
    chk("rd nvm", 16'(rdv), 16'h00c6);
  endtask
  task automatic t_offset;
    logic [7:0] t;
    int o;
    int k;
    for (int j = 0; j < 2; j++)
    begin
      t = j ? 8'h7f : 8'h80;
      i_host.wr(CMD_OUTPUT_OFFSET_TRIM, t, ok);
      for (int s = 0; s < 4; s++)
      begin
        step = 2'(s);
        repeat (1100) @(negedge clk_sys);
        k = (s == 1 || s == 2) ? 10 : 20;
        o = $signed(t) * k / 10;
        chk("offset", 16'(voff), 16'(o));
        chk("vref", 16'(vref), 16'(64 * k + o));
      end
    end
  endtask
  task automatic t_source;
    src = 2'h0;
    repeat (1100) @(negedge clk_sys);
    chk("off idle", 16'(voff), 16'h0000);
    chk("vref ext", 16'(vref), 16'(33 * 20));
    src = 2'h2;
    repeat (1100) @(negedge clk_sys);
    chk("vref ser", 16'(vref), 16'(64 * 20 + 254));
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_comp();
    t_offset();
    t_source();
    t_nvm();
    final_report();
  end
  // A hung handshake would otherwise stall the run without a verdict.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      final_report();
    end
  end
endmodule // vout_offset_comp_regs_test
bind vout_offset_comp_regs vout_regs_asserts i_chk (.clk_sys(clk_sys),
  .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .vout_source_select(vout_source_select),
  .offset_applied_halfmv(offset_applied_halfmv),
  .ac_path_gain(ac_path_gain), .ac_load_line(ac_load_line),
  .ac_path_gain_tenths(ac_path_gain_tenths),
  .ac_load_line_tenths(ac_load_line_tenths),
  .ac_path_gain_reserved(ac_path_gain_reserved));
